// ==== core/fscd_handler.sv ====
// Service handler end: owns the four call bytes, the configuration store and
// the Flash command outputs. Assumes the caller follows the call sequence.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "fscd_defs.svh"
module fscd_handler
  import fscd_pkg::*;
(
  fscd_if.handler link, // Call link
  output logic [7:0] value_out, // Value byte mirror
  output logic flash_prog_start, // Program latches pulse
  output logic flash_erase_start, // Block erase pulse
  output logic [7:0] flash_erase_block, // Erase block high byte
  output logic [7:0] hardware_security_byte, // Fuse byte
  output logic busy // Service in progress
);
  parameter logic [7:0] MANUF_CODE = 8'h11; // Arbitrary
  parameter logic [7:0] ID1_CODE = 8'h22; // Arbitrary
  parameter logic [7:0] ID2_CODE = 8'h33; // Arbitrary
  parameter logic [7:0] ID3_CODE = 8'h44; // Arbitrary
  parameter logic [7:0] LOADER_VERSION = 8'h10; // Arbitrary
  parameter int PAGE_CYCLES = `FSCD_PAGE_CYCLES;

  logic [7:0] command_selector_reg;
  logic [7:0] value_byte_reg;
  logic [7:0] high_operand_reg;
  logic [7:0] low_operand_reg;
  logic [7:0] cfg_reg [0:6];
  logic [7:0] fuse_reg;
  logic busy_reg;
  fscd_state_type state_reg;
  fscd_state_type state_next;
  logic [31:0] wait_reg;
  logic [31:0] wait_next;
  logic returned_reg;
  logic restart_reg;
  logic prog_reg;
  logic erase_reg;
  logic [7:0] erase_blk_reg;

  // Pages per erase block; zero marks an undefined block
  function automatic logic [15:0] block_pages(input logic [7:0] hi);
    if (hi == `FSCD_BLK0_HI)
      block_pages = `FSCD_BLK0_PAGES;
    else if (hi == `FSCD_BLK1_HI)
      block_pages = `FSCD_BLK1_PAGES;
    else if (hi == `FSCD_BLK2_HI)
      block_pages = `FSCD_BLK2_PAGES;
    else
      block_pages = 16'h0000;
  endfunction

  wire call_hit = link.jump && link.boot_space_enable
                  && link.jump_addr == `FSCD_ENTRY_CALL;
  wire boot_hit = link.jump && link.boot_space_enable
                  && link.jump_addr == `FSCD_ENTRY_BOOT;
  wire is_cfg_sel = low_operand_reg <= `FSCD_SEL_MAX_CFG;
  wire [2:0] cfg_idx = low_operand_reg[2:0];
  wire [15:0] pages = block_pages(high_operand_reg);
  wire is_erase = command_selector_reg == `FSCD_CMD_ERASE && pages != 16'h0000;
  wire is_prog = command_selector_reg == `FSCD_CMD_PROG;
  wire is_wr_cfg = command_selector_reg == `FSCD_CMD_WR_CFG && is_cfg_sel;
  wire is_wr_fuse = command_selector_reg == `FSCD_CMD_WR_FUSE;
  // Erase time scales with the page count of the chosen block
  wire [31:0] erase_cycles = 32'(pages) * 32'(PAGE_CYCLES);
  wire rd_cfg = command_selector_reg == `FSCD_CMD_RD_CFG;
  wire rd_fuse = command_selector_reg == `FSCD_CMD_RD_FUSE && low_operand_reg == 8'h00;
  wire rd_ver = command_selector_reg == `FSCD_CMD_RD_VER && low_operand_reg == 8'h00;
  wire rd_ok = (rd_cfg && (is_cfg_sel || low_operand_reg == `FSCD_SEL_MANUF
               || low_operand_reg == `FSCD_SEL_ID1 || low_operand_reg == `FSCD_SEL_ID2
               || low_operand_reg == `FSCD_SEL_ID3)) || rd_fuse || rd_ver;
  wire [7:0] rd_value =
    rd_fuse ? fuse_reg :
    rd_ver ? LOADER_VERSION :
    (rd_cfg && is_cfg_sel) ? cfg_reg[cfg_idx] :
    low_operand_reg == `FSCD_SEL_MANUF ? MANUF_CODE :
    low_operand_reg == `FSCD_SEL_ID1 ? ID1_CODE :
    low_operand_reg == `FSCD_SEL_ID2 ? ID2_CODE : ID3_CODE;

  // Handler reaches nothing but the four call bytes and its own store
  always_comb
  begin
    state_next = state_reg;
    wait_next = wait_reg;
    case (state_reg)
      FSCD_IDLE:
        if (boot_hit)
          state_next = FSCD_BOOT;
        else if (call_hit)
          state_next = FSCD_DECODE;
      FSCD_DECODE:
      begin
        state_next = FSCD_BUSY;
        if (is_erase)
          wait_next = erase_cycles;
        else if (is_prog || is_wr_cfg || is_wr_fuse)
          wait_next = 32'(PAGE_CYCLES);
        else
          wait_next = 32'd1;
      end
      FSCD_BUSY:
      begin
        wait_next = wait_reg - 32'd1;
        if (wait_reg <= 32'd1)
          state_next = FSCD_DONE;
      end
      FSCD_DONE:
        state_next = FSCD_IDLE;
      FSCD_BOOT:
        state_next = FSCD_IDLE;
      default:
        state_next = FSCD_IDLE;
    endcase
  end

  wire decoding = state_reg == FSCD_DECODE;
  wire finishing = state_reg == FSCD_BUSY && wait_reg <= 32'd1;

  always_ff @(posedge link.clk)
  begin
    if (link.rst || state_reg == FSCD_BOOT)
    begin
      state_reg <= FSCD_IDLE;
      wait_reg <= 32'd0;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg <= wait_next;
    end
  end

  // Busy tracks the state register edge for edge but comes from its own flop
  always_ff @(posedge link.clk)
  begin
    if (link.rst || state_reg == FSCD_BOOT)
      busy_reg <= 1'b0;
    else
      busy_reg <= state_next != FSCD_IDLE;
  end

  // Call bytes: caller writes while idle; handler posts read results
  always_ff @(posedge link.clk)
  begin
    if (link.rst)
    begin
      command_selector_reg <= 8'h00;
      value_byte_reg <= 8'h00;
      high_operand_reg <= 8'h00;
      low_operand_reg <= 8'h00;
    end
    else if (finishing && rd_ok)
      value_byte_reg <= rd_value;
    else if (link.ram_we && state_reg == FSCD_IDLE)
    begin
      if (link.ram_addr == `FSCD_ADDR_CMD)
        command_selector_reg <= link.ram_wdata;
      else if (link.ram_addr == `FSCD_ADDR_VAL)
        value_byte_reg <= link.ram_wdata;
      else if (link.ram_addr == `FSCD_ADDR_HI)
        high_operand_reg <= link.ram_wdata;
      else if (link.ram_addr == `FSCD_ADDR_LO)
        low_operand_reg <= link.ram_wdata;
    end
  end

  always_ff @(posedge link.clk)
  begin
    if (link.rst)
    begin
      for (int i = 0; i < 7; i++)
        cfg_reg[i] <= `FSCD_CFG_RESET;
      fuse_reg <= `FSCD_FUSE_RESET;
    end
    else if (finishing && is_wr_cfg)
      cfg_reg[cfg_idx] <= value_byte_reg;
    else if (finishing && is_wr_fuse)
      fuse_reg <= value_byte_reg;
  end

  always_ff @(posedge link.clk)
  begin
    if (link.rst)
    begin
      prog_reg <= 1'b0;
      erase_reg <= 1'b0;
      erase_blk_reg <= 8'h00;
      returned_reg <= 1'b0;
      restart_reg <= 1'b0;
    end
    else
    begin
      prog_reg <= decoding && is_prog;
      erase_reg <= decoding && is_erase;
      if (decoding && is_erase)
        erase_blk_reg <= high_operand_reg;
      returned_reg <= finishing;
      restart_reg <= state_reg == FSCD_IDLE && boot_hit;
    end
  end

  // Interrupt enable is not an input or output here, so it stays with the caller
  assign link.returned = returned_reg;
  assign link.loader_restart = restart_reg;
  assign value_out = value_byte_reg;
  assign flash_prog_start = prog_reg;
  assign flash_erase_start = erase_reg;
  assign flash_erase_block = erase_blk_reg;
  assign hardware_security_byte = fuse_reg;
  assign busy = busy_reg;
endmodule

// ==== core/fscd_defs.svh ====
// Constants for the flash service call decoder: call variable offsets, commands,
// selectors, fuse masks and timing counts. Included by the package and both ends.
`ifndef FSCD_DEFS_SVH
`define FSCD_DEFS_SVH
`define FSCD_ADDR_CMD 8'h1C
`define FSCD_ADDR_VAL 8'h1D
`define FSCD_ADDR_HI 8'h1E
`define FSCD_ADDR_LO 8'h1F
`define FSCD_ENTRY_CALL 16'hFFC0
`define FSCD_ENTRY_BOOT 16'hF400
`define FSCD_CMD_ERASE 8'h00
`define FSCD_CMD_WR_CFG 8'h04
`define FSCD_CMD_RD_CFG 8'h05
`define FSCD_CMD_WR_FUSE 8'h07
`define FSCD_CMD_RD_FUSE 8'h08
`define FSCD_CMD_PROG 8'h0D
`define FSCD_CMD_RD_VER 8'h0E
`define FSCD_SEL_MAX_CFG 8'h06
`define FSCD_SEL_MANUF 8'h30
`define FSCD_SEL_ID1 8'h31
`define FSCD_SEL_ID2 8'h60
`define FSCD_SEL_ID3 8'h61
`define FSCD_BLK0_HI 8'h00
`define FSCD_BLK1_HI 8'h20
`define FSCD_BLK2_HI 8'h40
`define FSCD_BLK0_PAGES 16'd32
`define FSCD_BLK1_PAGES 16'd32
`define FSCD_BLK2_PAGES 16'd64
`define FSCD_MASK_CLK_DBL 8'h7F
`define FSCD_MASK_BOOT_JUMP 8'hBF
`define FSCD_MASK_OSC1 8'hDF
`define FSCD_MASK_OSC0 8'hEF
`define FSCD_CFG_RESET 8'hFF
`define FSCD_FUSE_RESET 8'hFF
`define FSCD_PAGE_TIME_NS 32'd10000
`define FSCD_CLK_NS 32'd5
`define FSCD_PAGE_CYCLES (`FSCD_PAGE_TIME_NS / `FSCD_CLK_NS)
`endif

// ==== core/fscd_pkg.sv ====
// Types shared by both ends of the flash service call decoder.
// Assumes fscd_defs.svh is on the include path.
package fscd_pkg;
  `include "fscd_defs.svh"
  typedef enum logic [2:0]
  {
    FSCD_IDLE = 3'b000,
    FSCD_DECODE = 3'b001,
    FSCD_BUSY = 3'b011,
    FSCD_DONE = 3'b010,
    FSCD_BOOT = 3'b110
  } fscd_state_type;
endpackage

// ==== core/fscd_if.sv ====
// Link between application core (caller) and the service handler.
// Assumes one clock and one synchronous reset shared by both ends.
`timescale 1ns/1ps
interface fscd_if
(
  input wire logic clk,
  input wire logic rst
);
  logic [7:0] ram_addr;
  logic [7:0] ram_wdata;
  logic ram_we;
  logic [7:0] ram_rdata;
  logic [15:0] jump_addr;
  logic jump;
  logic boot_space_enable;
  logic returned;
  logic loader_restart;
  modport caller
  (
    input clk, rst, returned, loader_restart,
    output ram_addr, ram_wdata, ram_we, ram_rdata, jump_addr, jump, boot_space_enable
  );
  modport handler
  (
    input clk, rst, ram_addr, ram_wdata, ram_we, jump_addr, jump, boot_space_enable,
    output returned, loader_restart
  );
endinterface

// ==== core/fscd_caller.sv ====
// Caller end: sequences one service call from a user request port.
// Assumes the handler end is joined on the same interface.
`timescale 1ns/1ps
`include "fscd_defs.svh"
module fscd_caller
  import fscd_pkg::*;
(
  fscd_if.caller link, // Call link
  input wire logic req, // Start a call, one cycle
  input wire logic restart_req, // Restart loader, one cycle
  input wire logic [7:0] cmd, // Command selector
  input wire logic [7:0] val, // Value byte
  input wire logic [7:0] hi, // High operand
  input wire logic [7:0] lo, // Low operand
  output logic irq_enable, // Interrupt enable
  output logic wdt_kick, // Watchdog service pulse
  output logic done, // Call returned pulse
  output logic caller_busy // Call in progress
);
  logic [2:0] step_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic we_reg;
  logic jump_reg;
  logic [15:0] jaddr_reg;
  logic ben_reg;
  logic ien_reg;
  logic kick_reg;
  logic done_reg;
  logic cbusy_reg;
  logic [7:0] b_reg [0:3];

  always_ff @(posedge link.clk)
  begin
    if (link.rst)
    begin
      step_reg <= 3'd0;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      we_reg <= 1'b0;
      jump_reg <= 1'b0;
      jaddr_reg <= 16'h0000;
      ben_reg <= 1'b0;
      ien_reg <= 1'b1;
      kick_reg <= 1'b0;
      done_reg <= 1'b0;
      cbusy_reg <= 1'b0;
      for (int i = 0; i < 4; i++)
        b_reg[i] <= 8'h00;
    end
    else
    begin
      we_reg <= 1'b0;
      jump_reg <= 1'b0;
      kick_reg <= 1'b0;
      done_reg <= 1'b0;
      if (step_reg == 3'd0 && restart_req)
      begin
        ben_reg <= 1'b1;
        jump_reg <= 1'b1;
        jaddr_reg <= `FSCD_ENTRY_BOOT;
      end
      else if (step_reg == 3'd0 && req)
      begin
        b_reg[0] <= cmd;
        b_reg[1] <= val;
        b_reg[2] <= hi;
        b_reg[3] <= lo;
        ien_reg <= 1'b0;
        kick_reg <= 1'b1;
        step_reg <= 3'd1;
        cbusy_reg <= 1'b1;
      end
      else if (step_reg >= 3'd1 && step_reg <= 3'd4)
      begin
        we_reg <= 1'b1;
        addr_reg <= `FSCD_ADDR_CMD + 8'(step_reg - 3'd1);
        wdata_reg <= b_reg[2'(step_reg - 3'd1)];
        step_reg <= step_reg + 3'd1;
      end
      else if (step_reg == 3'd5)
      begin
        ben_reg <= 1'b1;
        jump_reg <= 1'b1;
        jaddr_reg <= `FSCD_ENTRY_CALL;
        step_reg <= 3'd6;
      end
      else if (step_reg == 3'd6 && link.returned)
      begin
        ien_reg <= 1'b1;
        done_reg <= 1'b1;
        step_reg <= 3'd0;
        cbusy_reg <= 1'b0;
      end
    end
  end

  // EEPROM and Flash reads never travel over the call link
  assign link.ram_addr = addr_reg;
  assign link.ram_wdata = wdata_reg;
  assign link.ram_we = we_reg;
  assign link.ram_rdata = 8'h00;
  assign link.jump = jump_reg;
  assign link.jump_addr = jaddr_reg;
  assign link.boot_space_enable = ben_reg;
  assign irq_enable = ien_reg;
  assign wdt_kick = kick_reg;
  assign done = done_reg;
  assign caller_busy = cbusy_reg;
endmodule

// ==== dv/fscd_sva.sv ====
// Checker for the call link between caller and service handler.
// Assumes one clock and the link signals handed in as plain inputs.
`timescale 1ns/1ps
module fscd_sva
(
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic [7:0] ram_addr, // Call byte address
  input wire logic ram_we, // Call byte write
  input wire logic [15:0] jump_addr, // Jump target
  input wire logic jump, // Jump pulse
  input wire logic boot_space_enable, // Boot space enable
  input wire logic returned, // Service finished
  input wire logic loader_restart // Loader restart
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_call_bytes: assert property (
    ram_we && ram_addr == 8'h1C |=> ram_we && ram_addr == 8'h1D
    ##1 ram_we && ram_addr == 8'h1E ##1 ram_we && ram_addr == 8'h1F)
    else $error("call bytes out of order");
  chk_entry_jump: assert property (
    ram_we && ram_addr == 8'h1F |=> jump && jump_addr == 16'hFFC0)
    else $error("no entry jump after call bytes");
  chk_boot_enable: assert property (jump |-> boot_space_enable)
    else $error("jump without boot space enable");
  chk_return_bound: assert property (
    jump && jump_addr == 16'hFFC0 |-> ##[2:400] returned)
    else $error("service did not return");
  chk_quiet_wait: assert property (
    jump && jump_addr == 16'hFFC0 |=> (!ram_we && !jump) until returned)
    else $error("link activity during service");
  chk_return_pulse: assert property ($rose(returned) |=> $fell(returned))
    else $error("return not a pulse");
  chk_restart_entry: assert property (
    jump && jump_addr == 16'hF400 && boot_space_enable |-> ##[1:4] loader_restart)
    else $error("loader restart missing");
  chk_restart_pulse: assert property (loader_restart |=> !loader_restart)
    else $error("restart not a pulse");
endmodule

// ==== dv/flash_service_call_decoder_bench.sv ====
// Self-checking bench: caller and handler joined on one link.
// Assumes the core package, interface and both ends are compiled first.
`timescale 1ns/1ps
module flash_service_call_decoder_bench;
  import fscd_pkg::*;
  localparam int PC = 4;
  localparam logic [7:0] VER = 8'h9E; // Arbitrary
  logic [7:0] idc [4] = '{8'h5A, 8'h6B, 8'h7C, 8'h8D}; // Arbitrary
  logic [7:0] ids [4] = '{8'h30, 8'h31, 8'h60, 8'h61};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic restart_req = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [7:0] val = 8'h00;
  logic [7:0] hi = 8'h00;
  logic [7:0] lo = 8'h00;
  logic irq_enable, wdt_kick, done, caller_busy, prog_start, erase_start, busy;
  logic [7:0] value_out, erase_blk, fuse_byte;
  int bad_count = 0;
  int samples_checked = 0;
  int prog_n, erase_n, busy_n, kick_n, irq_low, cbusy_n;
  always #2.5 clk = ~clk;
  fscd_if i_fscd_if (.clk(clk), .rst(rst));
  fscd_handler #(.MANUF_CODE(8'h5A), .ID1_CODE(8'h6B), .ID2_CODE(8'h7C), .ID3_CODE(8'h8D),
    .LOADER_VERSION(VER), .PAGE_CYCLES(PC)) i_fscd_handler (.link(i_fscd_if),
    .value_out(value_out), .flash_prog_start(prog_start), .flash_erase_start(erase_start),
    .flash_erase_block(erase_blk), .hardware_security_byte(fuse_byte), .busy(busy));
  fscd_caller i_fscd_caller (.link(i_fscd_if), .req(req), .restart_req(restart_req),
    .cmd(cmd), .val(val), .hi(hi), .lo(lo), .irq_enable(irq_enable), .wdt_kick(wdt_kick),
    .done(done), .caller_busy(caller_busy));
  fscd_sva u_chk (.clk(clk), .rst(rst), .ram_addr(i_fscd_if.ram_addr),
    .ram_we(i_fscd_if.ram_we), .jump_addr(i_fscd_if.jump_addr), .jump(i_fscd_if.jump),
    .boot_space_enable(i_fscd_if.boot_space_enable), .returned(i_fscd_if.returned),
    .loader_restart(i_fscd_if.loader_restart));
  task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t byte expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic check_flag(input logic ok);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("ERROR %0t flag check failed", $time);
    end
  endtask
  task automatic final_report;
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One full service call; tallies pulses and busy cycles until done
  task automatic call(input logic [7:0] c, input logic [7:0] v, input logic [7:0] h,
    input logic [7:0] l);
    int n;
    n = 0;
    prog_n = 0;
    erase_n = 0;
    busy_n = 0;
    kick_n = 0;
    irq_low = 0;
    cbusy_n = 0;
    @(posedge clk);
    req <= 1'b1;
    cmd <= c;
    val <= v;
    hi <= h;
    lo <= l;
    @(posedge clk);
    req <= 1'b0;
    #1;
    kick_n += (wdt_kick === 1'b1);
    while (done !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      #1;
      n++;
      prog_n += (prog_start === 1'b1);
      erase_n += (erase_start === 1'b1);
      busy_n += (busy === 1'b1);
      kick_n += (wdt_kick === 1'b1);
      irq_low += (irq_enable === 1'b0);
      cbusy_n += (caller_busy === 1'b1);
    end
    check_flag(done === 1'b1);
    check_flag(kick_n == 1);
    check_flag(cbusy_n == busy_n + 5);
    check_flag(irq_low == cbusy_n);
    @(posedge clk);
    #1;
    check_flag(irq_low > 0 && irq_enable === 1'b1);
  endtask
  task automatic t_config;
    for (int s = 0; s <= 6; s++)
    begin
      call(8'h05, 8'h00, 8'h00, 8'(s));
      check_byte(8'hFF, value_out);
      call(8'h04, 8'hA0 + 8'(s), 8'h00, 8'(s));
      check_flag(busy_n >= PC && prog_n + erase_n == 0);
    end
    call(8'h04, 8'h33, 8'h00, 8'h07);
    call(8'h55, 8'h44, 8'h00, 8'h00);
    check_flag(prog_n + erase_n == 0);
    check_byte(8'h44, value_out);
    for (int s = 0; s <= 6; s++)
    begin
      call(8'h05, 8'h00, 8'h00, 8'(s));
      check_byte(8'hA0 + 8'(s), value_out);
    end
  endtask
  task automatic t_ident;
    for (int i = 0; i < 4; i++)
    begin
      call(8'h05, 8'h00, 8'h00, ids[i]);
      check_byte(idc[i], value_out);
    end
    call(8'h0E, 8'h00, 8'h00, 8'h00);
    check_byte(VER, value_out);
  endtask
  task automatic t_fuse;
    logic [7:0] f [4] = '{8'h7F, 8'h3F, 8'hBF, 8'hFF};
    for (int i = 0; i < 4; i++)
    begin
      call(8'h07, f[i], 8'h00, 8'h00);
      check_byte(f[i], fuse_byte);
      call(8'h08, 8'h00, 8'h00, 8'h00);
      check_byte(f[i], value_out);
    end
  endtask
  task automatic t_flash;
    logic [7:0] b [3] = '{8'h00, 8'h20, 8'h40};
    int pg [3] = '{32, 32, 64};
    call(8'h0D, 8'h00, 8'h00, 8'h00);
    check_flag(prog_n == 1 && erase_n == 0 && busy_n >= PC && busy_n <= PC + 3);
    for (int i = 0; i < 3; i++)
    begin
      call(8'h00, 8'h00, b[i], 8'h00);
      check_flag(erase_n == 1 && prog_n == 0);
      check_byte(b[i], erase_blk);
      check_flag(busy_n >= pg[i] * PC && busy_n <= pg[i] * PC + 3);
    end
    call(8'h00, 8'h00, 8'h10, 8'h00);
    check_flag(erase_n == 0);
  endtask
  task automatic t_restart;
    int n;
    n = 0;
    @(posedge clk);
    restart_req <= 1'b1;
    @(posedge clk);
    restart_req <= 1'b0;
    while (i_fscd_if.loader_restart !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check_flag(i_fscd_if.loader_restart === 1'b1);
    repeat (4) @(posedge clk);
    call(8'h0E, 8'h00, 8'h00, 8'h00);
    check_byte(VER, value_out);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_config();
    t_ident();
    t_fuse();
    t_flash();
    t_restart();
    final_report();
  end
  initial
  begin
    #100000;
    bad_count++;
    final_report();
  end
endmodule
